// file: design/tmw_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/1ns
`default_nettype none
module tmw_axil_slave
  import tmw_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output tmw_wreq_t        wreq,
  input  wire logic        wr_hit,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_hit
);
  tmw_axi_st_t st_ff;
  tmw_axi_st_t nxt_st;
  logic        fire;

  // The write strobe waits for both halves, so address and data may come in either order.
  assign fire          = st_ff.have_aw & st_ff.have_w & ~st_ff.bvalid;
  assign wreq          = '{en: fire, addr: st_ff.awaddr, data: st_ff.wdata, strb: st_ff.wstrb};
  assign rd_addr       = st_ff.araddr;
  assign s_axi_awready = st_ff.awrdy;
  assign s_axi_wready  = st_ff.wrdy;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_arready = st_ff.arrdy;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign s_axi_rvalid  = st_ff.rvalid;

  always_comb begin
    nxt_st = st_ff;
    if (s_axi_awvalid && st_ff.awrdy) begin
      nxt_st.have_aw = 1'b1;
      nxt_st.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wrdy) begin
      nxt_st.have_w = 1'b1;
      nxt_st.wdata  = s_axi_wdata;
      nxt_st.wstrb  = s_axi_wstrb;
    end
    if (fire) begin
      nxt_st.have_aw = 1'b0;
      nxt_st.have_w  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = wr_hit ? TMW_RESP_OKAY : TMW_RESP_SLVERR;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arrdy) begin
      nxt_st.araddr = s_axi_araddr;
      nxt_st.rpend  = 1'b1;
    end
    if (st_ff.rpend) begin
      nxt_st.rpend  = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_data;
      nxt_st.rresp  = rd_hit ? TMW_RESP_OKAY : TMW_RESP_SLVERR;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    nxt_st.awrdy = ~nxt_st.have_aw & ~nxt_st.bvalid;
    nxt_st.wrdy  = ~nxt_st.have_w & ~nxt_st.bvalid;
    nxt_st.arrdy = ~nxt_st.rpend & ~nxt_st.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : tmw_axil_slave
`default_nettype wire

// file: design/tmw_pkg.sv
// Shared constants and types for the 8-bit timer waveform mode control block.
package tmw_pkg;

  localparam logic [7:0] TMW_OFF_CTRL_A = 8'h30;
  localparam logic [7:0] TMW_OFF_CTRL_B = 8'h34;
  localparam logic [7:0] TMW_OFF_CNT    = 8'h38;
  localparam logic [7:0] TMW_OFF_CMPA   = 8'h3C;
  localparam logic [7:0] TMW_OFF_CMPB   = 8'h40;
  localparam logic [7:0] TMW_OFF_STAT   = 8'h44;

  localparam logic [7:0] TMW_CTRL_A_RST   = 8'h00;
  localparam logic [7:0] TMW_CTRL_A_WMASK = 8'hF3;
  localparam int         TMW_COMA_LSB     = 6;
  localparam int         TMW_COMB_LSB     = 4;
  localparam int         TMW_EXT_BIT      = 3;
  localparam int         TMW_RUN_BIT      = 0;
  localparam int         TMW_OVF_BIT      = 0;

  localparam logic [7:0] TMW_MAX    = 8'hFF;
  localparam logic [7:0] TMW_BOTTOM = 8'h00;

  localparam logic [2:0] TMW_WGM_NORMAL = 3'h0;
  localparam logic [2:0] TMW_WGM_PC_FF  = 3'h1;
  localparam logic [2:0] TMW_WGM_CTC    = 3'h2;
  localparam logic [2:0] TMW_WGM_FP_FF  = 3'h3;
  localparam logic [2:0] TMW_WGM_RSV4   = 3'h4;
  localparam logic [2:0] TMW_WGM_PC_CMP = 3'h5;
  localparam logic [2:0] TMW_WGM_RSV6   = 3'h6;
  localparam logic [2:0] TMW_WGM_FP_CMP = 3'h7;

  localparam logic [1:0] TMW_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TMW_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    TMW_CLS_NORMAL = 4'b0001,
    TMW_CLS_CTC    = 4'b0010,
    TMW_CLS_FAST   = 4'b0100,
    TMW_CLS_PHASE  = 4'b1000
  } tmw_class_t;

  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } tmw_wreq_t;

  typedef struct packed {
    logic        awrdy;
    logic        wrdy;
    logic        have_aw;
    logic        have_w;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic [7:0]  araddr;
    logic        rpend;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tmw_axi_st_t;

  typedef struct packed {
    logic wave;
    logic conn;
  } tmw_chan_st_t;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic       ext;
    logic       run;
    logic [7:0] cnt;
    logic       dir_down;
    logic       block;
    logic [7:0] cmpa_buf;
    logic [7:0] cmpb_buf;
    logic [7:0] cmpa_act;
    logic [7:0] cmpb_act;
    logic       ovf;
  } tmw_top_st_t;

endpackage : tmw_pkg

// file: design/tmw_timer8.sv
// Top of the 8-bit timer: registers, mode decode, counter and overflow flag.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - A nonzero compare output mode hands that channel's pin to its waveform; the code leaves PWM code 1 off the pin unless it is channel A with extension 1.
// - Non-PWM channel A: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Non-PWM channel B: 0 off, 1 toggle, 2 clear, 3 set on match.
// - PWM channel A code 1: off when extension is 0, toggle when 1.
// - Fast PWM: code 2 clears on match, sets at bottom; code 3 inverse.
// - Fast PWM: compare equal to top with high bit set ignores match.
// - Phase PWM: code 2 clears rising match, sets falling match; code 3 inverse.
// - Phase PWM: compare equal to top with high bit set acts at top.
// - Control A bits 3:2 always read zero.
// - Mode is extension bit above control A bits 1:0.
// - Modes: 0 normal, 1/5 phase, 2 clear-on-match, 3/7 fast, 4/6 reserved.
// - Top is 0xFF in modes 0,1,3 and channel A compare in 2,5,7.
// - Compare writes apply at once, at top, or at bottom per mode.
// - Overflow flag at MAX in 0,2,3; bottom in 1,5; top in 7.
// - MAX is 0xFF and BOTTOM is 0x00.
// - Phase PWM counts up to top, then down to bottom, repeatedly.
// - Fast PWM counts up to top, then returns to zero next cycle.
module tmw_timer8
  import tmw_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             chan_a_wave_out,
  output logic             chan_a_pin_override,
  output logic             chan_b_wave_out,
  output logic             chan_b_pin_override,
  output logic             overflow_flag
);
  tmw_top_st_t st_ff;
  tmw_top_st_t nxt_st;
  tmw_wreq_t   wreq;
  tmw_class_t  cls;
  logic [2:0]  waveform_mode;
  logic        reserved_mode;
  logic [7:0]  top_val;
  logic        tick;
  logic        at_top;
  logic        match_a;
  logic        match_b;
  logic        ovf_evt;
  logic        cmp_load;
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_byte;
  logic [31:0] rd_data;
  logic        cnt_wr;

  // The counter is never written while a match is wanted: a write blocks a match on the first counted cycle after it.
  assign tick          = st_ff.run;
  assign waveform_mode = {st_ff.ext, st_ff.ctrl_a[1:0]};
  assign reserved_mode = (waveform_mode == TMW_WGM_RSV4) || (waveform_mode == TMW_WGM_RSV6);
  assign top_val       = (waveform_mode == TMW_WGM_CTC || waveform_mode == TMW_WGM_PC_CMP ||
                          waveform_mode == TMW_WGM_FP_CMP) ? st_ff.cmpa_act : TMW_MAX;
  assign at_top        = tick && (st_ff.cnt == top_val);
  assign match_a       = tick && !st_ff.block && (st_ff.cnt == st_ff.cmpa_act);
  assign match_b       = tick && !st_ff.block && (st_ff.cnt == st_ff.cmpb_act);
  assign cnt_wr        = wreq.en && wreq.strb[0] && (wreq.addr == TMW_OFF_CNT);
  // Buffered modes load on the top cycle, so a new compare first counts from bottom in fast PWM and from top on the way down in phase PWM.
  assign cmp_load      = (cls == TMW_CLS_NORMAL) || (cls == TMW_CLS_CTC) ||
                         (at_top && (cls == TMW_CLS_PHASE || cls == TMW_CLS_FAST));
  assign rd_data       = {24'h00_0000, rd_byte};
  assign overflow_flag = st_ff.ovf;

  always_comb begin
    unique case (waveform_mode)
      TMW_WGM_NORMAL, TMW_WGM_RSV4, TMW_WGM_RSV6: cls = TMW_CLS_NORMAL;
      TMW_WGM_PC_FF, TMW_WGM_PC_CMP:              cls = TMW_CLS_PHASE;
      TMW_WGM_CTC:                                cls = TMW_CLS_CTC;
      TMW_WGM_FP_FF, TMW_WGM_FP_CMP:              cls = TMW_CLS_FAST;
    endcase
  end

  always_comb begin
    // Mode 7 flags at top because the counter may never reach MAX there.
    if (waveform_mode == TMW_WGM_FP_CMP) begin
      ovf_evt = at_top;
    end else if (cls == TMW_CLS_PHASE) begin
      ovf_evt = tick && st_ff.dir_down && (st_ff.cnt == TMW_BOTTOM);
    end else begin
      ovf_evt = tick && (st_ff.cnt == TMW_MAX);
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    unique case (wreq.addr)
      TMW_OFF_CTRL_A, TMW_OFF_CTRL_B, TMW_OFF_CNT,
      TMW_OFF_CMPA, TMW_OFF_CMPB, TMW_OFF_STAT: wr_hit = 1'b1;
      default:                                  wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    // Unmapped offsets answer with an error and a zero byte.
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    unique case (rd_addr)
      TMW_OFF_CTRL_A: rd_byte = st_ff.ctrl_a & TMW_CTRL_A_WMASK;
      TMW_OFF_CTRL_B: begin
        rd_byte[TMW_EXT_BIT] = st_ff.ext;
        rd_byte[TMW_RUN_BIT] = st_ff.run;
      end
      TMW_OFF_CNT:    rd_byte = st_ff.cnt;
      TMW_OFF_CMPA:   rd_byte = st_ff.cmpa_buf;
      TMW_OFF_CMPB:   rd_byte = st_ff.cmpb_buf;
      TMW_OFF_STAT:   rd_byte[TMW_OVF_BIT] = st_ff.ovf;
      default:        rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    if (cls != TMW_CLS_PHASE) begin
      nxt_st.dir_down = 1'b0;
    end
    if (tick) begin
      nxt_st.block = 1'b0;
      unique case (cls)
        TMW_CLS_NORMAL: nxt_st.cnt = st_ff.cnt + 8'h01;
        TMW_CLS_CTC, TMW_CLS_FAST: begin
          nxt_st.cnt = at_top ? TMW_BOTTOM : st_ff.cnt + 8'h01;
        end
        TMW_CLS_PHASE: begin
          // A top of zero would otherwise wrap; the counter then rests at bottom.
          if (!st_ff.dir_down) begin
            if (at_top) begin
              nxt_st.dir_down = 1'b1;
              nxt_st.cnt = (st_ff.cnt == TMW_BOTTOM) ? TMW_BOTTOM : st_ff.cnt - 8'h01;
            end else begin
              nxt_st.cnt = st_ff.cnt + 8'h01;
            end
          end else if (st_ff.cnt == TMW_BOTTOM) begin
            nxt_st.dir_down = 1'b0;
            nxt_st.cnt = (top_val == TMW_BOTTOM) ? TMW_BOTTOM : st_ff.cnt + 8'h01;
          end else begin
            nxt_st.cnt = st_ff.cnt - 8'h01;
          end
        end
      endcase
    end
    if (wreq.en && wreq.strb[0]) begin
      unique case (wreq.addr)
        TMW_OFF_CTRL_A: nxt_st.ctrl_a = wreq.data[7:0] & TMW_CTRL_A_WMASK;
        TMW_OFF_CTRL_B: begin
          nxt_st.ext = wreq.data[TMW_EXT_BIT];
          nxt_st.run = wreq.data[TMW_RUN_BIT];
        end
        TMW_OFF_CNT: begin
          nxt_st.cnt   = wreq.data[7:0];
          nxt_st.block = 1'b1;
        end
        TMW_OFF_CMPA: nxt_st.cmpa_buf = wreq.data[7:0];
        TMW_OFF_CMPB: nxt_st.cmpb_buf = wreq.data[7:0];
        TMW_OFF_STAT: begin
          if (wreq.data[TMW_OVF_BIT]) begin
            nxt_st.ovf = 1'b0;
          end
        end
        default: nxt_st.block = nxt_st.block;
      endcase
    end
    // The flag is set after the clear, so an event in the clearing cycle survives.
    if (ovf_evt) begin
      nxt_st.ovf = 1'b1;
    end
    if (cmp_load) begin
      nxt_st.cmpa_act = nxt_st.cmpa_buf;
      nxt_st.cmpb_act = nxt_st.cmpb_buf;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  tmw_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wreq          (wreq),
    .wr_hit        (wr_hit),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_hit        (rd_hit)
  );

  tmw_wave_chan #(.IS_CHAN_A(1'b1)) u_chan_a (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .cls               (cls),
    .reserved_mode     (reserved_mode),
    .output_mode       (st_ff.ctrl_a[TMW_COMA_LSB +: 2]),
    .waveform_mode_ext (st_ff.ext),
    .match             (match_a),
    .at_top            (at_top),
    .count_up          (!st_ff.dir_down),
    .cmp_is_top        (st_ff.cmpa_act == top_val),
    .wave_out          (chan_a_wave_out),
    .pin_override      (chan_a_pin_override)
  );

  tmw_wave_chan #(.IS_CHAN_A(1'b0)) u_chan_b (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .cls               (cls),
    .reserved_mode     (reserved_mode),
    .output_mode       (st_ff.ctrl_a[TMW_COMB_LSB +: 2]),
    .waveform_mode_ext (st_ff.ext),
    .match             (match_b),
    .at_top            (at_top),
    .count_up          (!st_ff.dir_down),
    .cmp_is_top        (st_ff.cmpb_act == top_val),
    .wave_out          (chan_b_wave_out),
    .pin_override      (chan_b_pin_override)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_rsvd_read_zero: assert property (
    (rd_addr == TMW_OFF_CTRL_A) |-> rd_byte[3:2] == 2'h0
  ) else $error("reserved control bits read nonzero");
  chk_mode_decode: assert property (
    (waveform_mode == TMW_WGM_PC_CMP) |-> (cls == TMW_CLS_PHASE && top_val == st_ff.cmpa_act)
  ) else $error("mode 5 decoded wrongly");
  chk_wrap_at_top: assert property (
    (tick && cls == TMW_CLS_FAST && st_ff.cnt == top_val && !cnt_wr) |=> st_ff.cnt == TMW_BOTTOM
  ) else $error("fast PWM did not return to bottom");
  chk_phase_turn: assert property (
    (at_top && cls == TMW_CLS_PHASE && !st_ff.dir_down && top_val != TMW_BOTTOM && !cnt_wr)
      |=> st_ff.dir_down && st_ff.cnt == $past(st_ff.cnt) - 8'h01
  ) else $error("phase PWM did not turn at top");
  chk_ovf_at_max: assert property (
    (tick && waveform_mode == TMW_WGM_NORMAL && st_ff.cnt == TMW_MAX) |=> overflow_flag
  ) else $error("overflow flag not set at MAX");
  chk_cmp_buffered: assert property (
    (cls == TMW_CLS_FAST && !at_top) |=> $stable(st_ff.cmpa_act)
  ) else $error("fast PWM compare updated away from bottom");

  // Counter end points, flag points and immediate compare loading, grouped by mode family.
  chk_ovf_phase_bottom: assert property (
    (tick && cls == TMW_CLS_PHASE && st_ff.dir_down && st_ff.cnt == TMW_BOTTOM)
      |=> overflow_flag
  ) else $error("overflow flag not set at phase bottom");
  chk_ovf_mode7_top: assert property (
    (waveform_mode == TMW_WGM_FP_CMP && at_top) |=> overflow_flag
  ) else $error("overflow flag not set at mode 7 top");
  chk_ctc_wrap: assert property (
    (tick && cls == TMW_CLS_CTC && st_ff.cnt == st_ff.cmpa_act && !cnt_wr) |=> st_ff.cnt == 8'h00
  ) else $error("clear-on-match did not wrap at compare A");
  chk_max_top_turn: assert property (
    (tick && waveform_mode == TMW_WGM_PC_FF && !st_ff.dir_down && st_ff.cnt == TMW_MAX)
      |=> st_ff.dir_down
  ) else $error("mode 1 did not turn at MAX");
  chk_phase_bounce: assert property (
    (tick && cls == TMW_CLS_PHASE && st_ff.dir_down && st_ff.cnt == TMW_BOTTOM &&
     top_val != TMW_BOTTOM && !cnt_wr) |=> !st_ff.dir_down && st_ff.cnt == 8'h01
  ) else $error("phase PWM did not turn at bottom");
  chk_cmp_immediate: assert property (
    (cls == TMW_CLS_NORMAL || cls == TMW_CLS_CTC) |=> st_ff.cmpa_act == st_ff.cmpa_buf
  ) else $error("compare not applied at once");
  cov_ovf_phase: cover property (cls == TMW_CLS_PHASE && ovf_evt);
  cov_ctc_match: cover property (cls == TMW_CLS_CTC && at_top);
  cov_mode7_top: cover property (waveform_mode == TMW_WGM_FP_CMP && at_top);

endmodule : tmw_timer8
`default_nettype wire

// file: design/tmw_wave_chan.sv
// One compare output channel: pin takeover and waveform set, clear and toggle.
`timescale 1ns/1ns
`default_nettype none
module tmw_wave_chan
  import tmw_pkg::*;
#(
  parameter bit IS_CHAN_A = 1'b1
)
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire tmw_class_t cls,
  input  wire logic       reserved_mode,
  input  wire logic [1:0] output_mode,
  input  wire logic       waveform_mode_ext,
  input  wire logic       match,
  input  wire logic       at_top,
  input  wire logic       count_up,
  input  wire logic       cmp_is_top,
  output logic            wave_out,
  output logic            pin_override
);
  tmw_chan_st_t st_ff;
  tmw_chan_st_t nxt_st;
  logic         pwm;
  logic         toggle_ok;
  logic         inv;

  assign pwm          = (cls == TMW_CLS_FAST) || (cls == TMW_CLS_PHASE);
  assign toggle_ok    = !pwm || (IS_CHAN_A && waveform_mode_ext);
  assign inv          = output_mode[0];
  assign wave_out     = st_ff.wave;
  assign pin_override = st_ff.conn;

  always_comb begin
    nxt_st = st_ff;
    // Code 1 in a PWM mode only reaches the pin where toggling exists.
    nxt_st.conn = (output_mode != 2'h0) && !(pwm && output_mode == 2'h1 && !toggle_ok);
    if (reserved_mode) begin
      nxt_st.wave = st_ff.wave;
    end else if (!pwm) begin
      if (match) begin
        unique case (output_mode)
          2'h0: nxt_st.wave = st_ff.wave;
          2'h1: nxt_st.wave = ~st_ff.wave;
          2'h2: nxt_st.wave = 1'b0;
          2'h3: nxt_st.wave = 1'b1;
        endcase
      end
    end else if (output_mode == 2'h1) begin
      if (toggle_ok && match) begin
        nxt_st.wave = ~st_ff.wave;
      end
    end else if (output_mode[1]) begin
      if (cls == TMW_CLS_FAST) begin
        // The bottom action wins over a match in the same cycle.
        if (at_top) begin
          nxt_st.wave = !inv;
        end else if (match && !cmp_is_top) begin
          nxt_st.wave = inv;
        end
      end else if (cmp_is_top) begin
        if (at_top) begin
          nxt_st.wave = !inv;
        end
      end else if (match) begin
        nxt_st.wave = count_up ? inv : !inv;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_toggle_on_match: assert property (
    (!pwm && !reserved_mode && output_mode == 2'h1 && match) |=> wave_out != $past(wave_out)
  ) else $error("non-PWM toggle did not toggle");
  chk_fast_bottom_level: assert property (
    (cls == TMW_CLS_FAST && output_mode[1] && at_top) |=> wave_out == !$past(inv)
  ) else $error("fast PWM bottom level wrong");
  chk_fast_top_ignore: assert property (
    (cls == TMW_CLS_FAST && output_mode[1] && cmp_is_top && !at_top) |=> $stable(wave_out)
  ) else $error("fast PWM match at top not ignored");
  chk_phase_direction: assert property (
    (cls == TMW_CLS_PHASE && output_mode[1] && match && !cmp_is_top)
      |=> wave_out == ($past(count_up) ? $past(inv) : !$past(inv))
  ) else $error("phase PWM match level wrong");
  chk_phase_top_level: assert property (
    (cls == TMW_CLS_PHASE && output_mode[1] && cmp_is_top && at_top) |=> wave_out == !$past(inv)
  ) else $error("phase PWM top level wrong");
  chk_pin_takeover: assert property (
    (!pwm && output_mode != 2'h0) |=> pin_override
  ) else $error("nonzero output mode did not take the pin");
  chk_pwm_code_one: assert property (
    (pwm && output_mode == 2'h1 && !toggle_ok) |=> !pin_override && $stable(wave_out)
  ) else $error("PWM code 1 not disconnected");
  cov_fast_bottom: cover property (cls == TMW_CLS_FAST && output_mode == 2'h2 && at_top);
  cov_phase_down: cover property (cls == TMW_CLS_PHASE && match && !count_up);

endmodule : tmw_wave_chan
`default_nettype wire

// file: dv/test_timer8_waveform_mode_control.sv
// Self-checking bench for the timer waveform mode control block.
`timescale 1ns/1ns
`default_nettype none
module test_timer8_waveform_mode_control
  import tmw_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, chan_a_wave_out, chan_a_pin_override, chan_b_wave_out;
  logic        chan_b_pin_override, overflow_flag, pin_a, dir_a;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, rb;
  int          error_cnt, compares, cyc;

  tmw_timer8 u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .chan_a_wave_out, .chan_a_pin_override, .chan_b_wave_out,
    .chan_b_pin_override, .overflow_flag);
  tmw_pin_model u_pin (.dir_out(dir_a), .port_val(1'b0), .override(chan_a_pin_override),
    .wave(chan_a_wave_out), .pin(pin_a));

  task automatic close_out();
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %0h", $time, m, got);
    end
  endtask : chk

  // Bready is dropped and one edge passes, so a following write never lands in the same step.
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rb = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axw

  task automatic axr(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axr

  // Counts high cycles over one or two whole settled periods, which is independent of the start phase.
  task automatic duty(input logic [7:0] ca, cb, oa, ob, input int per, ha, hb,
                      input logic [1:0] ov);
    int na;
    int nb;
    na = 0;
    nb = 0;
    axw(TMW_OFF_CTRL_B, 8'h00);
    axw(TMW_OFF_CTRL_A, 8'h00);
    axw(TMW_OFF_CNT, 8'h00);
    axw(TMW_OFF_CMPA, oa);
    axw(TMW_OFF_CMPB, ob);
    axw(TMW_OFF_CTRL_A, ca);
    axw(TMW_OFF_CTRL_B, cb);
    repeat (per) @(posedge aclk);
    repeat (per) begin
      @(posedge aclk);
      na += int'(chan_a_wave_out);
      nb += int'(chan_b_wave_out);
    end
    chk(na, ha, "wave a high count");
    chk(nb, hb, "wave b high count");
    chk({chan_a_pin_override, chan_b_pin_override}, ov, "pin override");
    chk(pin_a, chan_a_pin_override & chan_a_wave_out, "pin a level");
  endtask : duty

  task automatic reg_map();
    axr(TMW_OFF_CTRL_A);
    chk(rd, 32'h0000_0000, "control a reset");
    axw(TMW_OFF_CTRL_A, 8'hFF);
    chk(rb, TMW_RESP_OKAY, "control a write response");
    axr(TMW_OFF_CTRL_A);
    chk(rd, 32'h0000_00F3, "reserved bits");
    axw(8'h50, 8'hFF);
    chk(rb, TMW_RESP_SLVERR, "unmapped write");
    axr(8'h50);
    chk(rr, TMW_RESP_SLVERR, "unmapped read");
    chk(rd, 32'h0000_0000, "unmapped read data");
  endtask : reg_map

  task automatic ovf_clear();
    chk(overflow_flag, 1'b1, "overflow at max");
    axw(TMW_OFF_CTRL_B, 8'h00);
    axw(TMW_OFF_STAT, 8'h01);
    chk(overflow_flag, 1'b0, "overflow clear");
  endtask : ovf_clear

  // Run while the waveform is low, so only the pull-up can make the pin read high.
  task automatic pin_release();
    dir_a <= 1'b0;
    @(posedge aclk);
    chk(pin_a, 1'b1, "pin a released");
    dir_a <= 1'b1;
  endtask : pin_release

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    s_axi_wstrb = 4'hF;
    dir_a = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reg_map();
    duty(8'hE0, 8'h01, 8'h10, 8'h20, 256, 256, 0, 2'b11);
    ovf_clear();
    duty(8'hB0, 8'h09, 8'h10, 8'h20, 256, 256, 0, 2'b11);
    duty(8'hB2, 8'h09, 8'h10, 8'h20, 256, 256, 0, 2'b11);
    duty(8'h53, 8'h01, 8'h10, 8'h20, 256, 256, 0, 2'b00);
    duty(8'hB0, 8'h01, 8'h10, 8'h20, 256, 0, 256, 2'b11);
    pin_release();
    duty(8'h52, 8'h01, 8'h0F, 8'h05, 32, 16, 16, 2'b11);
    duty(8'hB3, 8'h01, 8'h80, 8'h40, 256, 129, 191, 2'b11);
    duty(8'hA3, 8'h09, 8'h7F, 8'h20, 256, 256, 66, 2'b11);
    duty(8'h63, 8'h09, 8'h7F, 8'h20, 256, 128, 66, 2'b11);
    duty(8'hB1, 8'h01, 8'h80, 8'h40, 510, 256, 382, 2'b11);
    duty(8'hA1, 8'h09, 8'h3F, 8'h10, 252, 252, 64, 2'b11);
    close_out();
  end
endmodule : test_timer8_waveform_mode_control
`default_nettype wire

// file: dv/tmw_pin_model.sv
// Port pin model standing beside the timer: direction bit, port data and pull-up.
`timescale 1ns/1ns
`default_nettype none
module tmw_pin_model (
  input  wire logic dir_out,
  input  wire logic port_val,
  input  wire logic override,
  input  wire logic wave,
  output logic      pin
);
  // An input pin has no driver, so the pull-up wins whatever the timer does.
  assign pin = dir_out ? (override ? wave : port_val) : 1'b1;
endmodule : tmw_pin_model
`default_nettype wire
